// ### src/base_timer_pkg.sv
package base_timer_pkg;
  // ==========================================================
  // Register map (word offsets, byte addresses)
  localparam logic [3:0] REG_CTRL_OFS = 4'h0;
  localparam logic [3:0] REG_CMP0_OFS = 4'h4;
  localparam logic [3:0] REG_COUNT_OFS = 4'h8;
  localparam logic [3:0] REG_STATUS_OFS = 4'hC;
  // ==========================================================
  // Control register field positions
  localparam int CTRL_GLOBAL_START_BIT = 0;
  localparam int CTRL_GROUP_START_BIT = 1;
  localparam int CTRL_MATCH_RESET_BIT = 2;
  localparam int CTRL_DIR_LO_BIT = 5;
  localparam int CTRL_DIR_HI_BIT = 6;
  // ==========================================================
  // Count direction modes
  localparam logic [1:0] MODE_UP = 2'h0;
  localparam logic [1:0] MODE_UPDOWN = 2'h1;
  localparam logic [1:0] MODE_TWO_PHASE = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;
  // ==========================================================
  // Count limits and reset values
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_MIN = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] MATCH_DELAY_COUNTS = 2'h2;
  // Status bit positions
  localparam int STAT_RUNNING_BIT = 0;
  localparam int STAT_DOWN_BIT = 1;
  localparam int STAT_EXT_RESET_BIT = 2;
endpackage

// ### src/pin_sync.sv
`timescale 1ns/100ps
// ==========================================================
// Two-stage synchroniser for asynchronous pin levels
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // Reset to the idle high level so pins do not fake a reset
  always_comb
  begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= '1;
      sync_q <= '1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule

// ### src/updown_base_timer.sv
// Behaviour
// - Two direction bits: 00 up, 01 up/down, 10 two-phase, 11 unused.
// - Counting starts once global or group start bit is written 1.
// - Up/down mode: count reaching FFFFh reverses into decrementing.
// - Up/down mode, match reset enabled: decrement starts two counts after compare zero match.
// - Up/down mode: decrementing count reaching 0000h turns back up.
// - Low level on either external interrupt pin clears the count.
`timescale 1ns/100ps
module updown_base_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic count_src_i,
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  input wire logic ext_irq_pin_a_n_i,
  input wire logic ext_irq_pin_b_n_i,
  output logic [15:0] count_o,
  output logic count_down_o
);
  // ==========================================================
  // Direction state machine
  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } dir_t;

  logic [7:0] ctrl;
  logic [15:0] compare_reg_zero;
  logic [4:0] pins_s;
  logic count_dir_sel_lo;
  logic count_dir_sel_hi;
  logic [1:0] mode;
  logic running;
  logic ext_reset;
  logic match_reset_enable;
  logic tick;
  logic src_prev_q;
  logic src_prev_d;
  logic a_prev_q;
  logic a_prev_d;
  logic [15:0] count_q;
  logic [15:0] count_d;
  dir_t dir_q;
  dir_t dir_d;
  logic [1:0] match_cnt_q;
  logic [1:0] match_cnt_d;
  logic match_arm_q;
  logic match_arm_d;
  logic qa_step;
  logic qa_up;

  // Step of one count in the selected direction
  function automatic logic [15:0] step(input logic [15:0] v, input logic up);
    step = up ? v + 16'h0001 : v - 16'h0001;
  endfunction

  // ==========================================================
  // Register slave
  wb_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .ctrl_o(ctrl),
    .cmp0_o(compare_reg_zero),
    .count_i(count_q),
    .status_i({ext_reset, dir_q == DIR_DOWN, running})
  );

  // ==========================================================
  // Every pin level passes two flops before use
  pin_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({count_src_i, phase_a_i, phase_b_i, ext_irq_pin_a_n_i, ext_irq_pin_b_n_i}),
    .sync_o(pins_s)
  );

  // Control field decode
  assign count_dir_sel_lo = ctrl[base_timer_pkg::CTRL_DIR_LO_BIT];
  assign count_dir_sel_hi = ctrl[base_timer_pkg::CTRL_DIR_HI_BIT];
  assign mode = {count_dir_sel_hi, count_dir_sel_lo};
  assign match_reset_enable = ctrl[base_timer_pkg::CTRL_MATCH_RESET_BIT];
  assign running = ctrl[base_timer_pkg::CTRL_GLOBAL_START_BIT]
                || ctrl[base_timer_pkg::CTRL_GROUP_START_BIT];
  assign ext_reset = !pins_s[1] || !pins_s[0];
  // Count-source rising edge is one count pulse
  assign tick = pins_s[4] && !src_prev_q;

  // Two-phase decode: a phase A edge counts, phase B picks direction
  always_comb
  begin
    qa_step = pins_s[3] != a_prev_q;
    qa_up = pins_s[3] ^ pins_s[2];
  end

  // ==========================================================
  // Counter, direction and match delay next values
  always_comb
  begin
    src_prev_d = pins_s[4];
    a_prev_d = pins_s[3];
    count_d = count_q;
    dir_d = dir_q;
    match_cnt_d = match_cnt_q;
    match_arm_d = match_arm_q;
    if (ext_reset)
    begin
      count_d = base_timer_pkg::COUNT_RESET;
      dir_d = DIR_UP;
      match_arm_d = 1'b0;
      match_cnt_d = 2'h0;
    end
    else if (!running)
    begin
      // Stopped: value holds, direction kept for resume
      count_d = count_q;
    end
    else
    begin
      case (mode)
        base_timer_pkg::MODE_UP:
        begin
          dir_d = DIR_UP;
          if (tick)
          begin
            count_d = step(count_q, 1'b1);
          end
        end
        base_timer_pkg::MODE_UPDOWN:
        begin
          if (tick)
          begin
            count_d = step(count_q, dir_q == DIR_UP);
            if (dir_q == DIR_UP)
            begin
              if (match_arm_q)
              begin
                // Keep climbing the extra counts past the match
                match_cnt_d = match_cnt_q + 2'h1;
                if (match_cnt_q + 2'h1 == base_timer_pkg::MATCH_DELAY_COUNTS)
                begin
                  dir_d = DIR_DOWN;
                  match_arm_d = 1'b0;
                  match_cnt_d = 2'h0;
                end
              end
              else if (match_reset_enable && count_q == compare_reg_zero)
              begin
                match_arm_d = 1'b1;
                match_cnt_d = 2'h1;
                if (base_timer_pkg::MATCH_DELAY_COUNTS == 2'h1)
                begin
                  dir_d = DIR_DOWN;
                  match_arm_d = 1'b0;
                end
              end
              if (count_q + 16'h0001 == base_timer_pkg::COUNT_MAX)
              begin
                dir_d = DIR_DOWN;
                match_arm_d = 1'b0;
                match_cnt_d = 2'h0;
              end
            end
            else if (count_q - 16'h0001 == base_timer_pkg::COUNT_MIN)
            begin
              dir_d = DIR_UP;
            end
          end
        end
        base_timer_pkg::MODE_TWO_PHASE:
        begin
          if (qa_step)
          begin
            count_d = step(count_q, qa_up);
            dir_d = qa_up ? DIR_UP : DIR_DOWN;
          end
        end
        default:
        begin
          // Unsupported combination: counter holds
          count_d = count_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // Same level as the synchroniser's reset, so no false pulse follows reset
      src_prev_q <= 1'b1;
      a_prev_q <= 1'b1;
      count_q <= base_timer_pkg::COUNT_RESET;
      dir_q <= DIR_UP;
      match_cnt_q <= 2'h0;
      match_arm_q <= 1'b0;
    end
    else
    begin
      src_prev_q <= src_prev_d;
      a_prev_q <= a_prev_d;
      count_q <= count_d;
      dir_q <= dir_d;
      match_cnt_q <= match_cnt_d;
      match_arm_q <= match_arm_d;
    end
  end

  assign count_o = count_q;
  assign count_down_o = dir_q == DIR_DOWN;
endmodule

// ### src/wb_regs.sv
`timescale 1ns/100ps
// ==========================================================
// Classic Wishbone slave holding the timer's control state
module wb_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [7:0] ctrl_o,
  output logic [15:0] cmp0_o,
  input wire logic [15:0] count_i,
  input wire logic [2:0] status_i
);
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [15:0] cmp0_q;
  logic [15:0] cmp0_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic take;

  // One-cycle answer; ack drops in the cycle after it is given
  assign take = cyc_i && stb_i && !ack_q;

  always_comb
  begin
    ctrl_d = ctrl_q;
    cmp0_d = cmp0_q;
    ack_d = take;
    dat_d = dat_q;
    if (take && we_i)
    begin
      if (adr_i == base_timer_pkg::REG_CTRL_OFS && sel_i[0])
      begin
        ctrl_d = dat_i[7:0];
      end
      if (adr_i == base_timer_pkg::REG_CMP0_OFS)
      begin
        if (sel_i[0])
        begin
          cmp0_d[7:0] = dat_i[7:0];
        end
        if (sel_i[1])
        begin
          cmp0_d[15:8] = dat_i[15:8];
        end
      end
    end
    if (take && !we_i)
    begin
      // Unmapped addresses read as zero and still ack
      case (adr_i)
        base_timer_pkg::REG_CTRL_OFS: dat_d = {24'h00_0000, ctrl_q};
        base_timer_pkg::REG_CMP0_OFS: dat_d = {16'h0000, cmp0_q};
        base_timer_pkg::REG_COUNT_OFS: dat_d = {16'h0000, count_i};
        base_timer_pkg::REG_STATUS_OFS: dat_d = {29'h0000_0000, status_i};
        default: dat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= 8'h00;
      cmp0_q <= 16'h0000;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      cmp0_q <= cmp0_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign dat_o = dat_q;
  assign ack_o = ack_q;
  assign ctrl_o = ctrl_q;
  assign cmp0_o = cmp0_q;
endmodule

// ### tb/updown_base_timer_bench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module updown_base_timer_bench;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc_i = 0;
  logic stb_i = 0;
  logic we_i = 0;
  logic [3:0] adr_i = 0;
  logic [3:0] sel_i = 0;
  logic [31:0] dat_i = 0;
  logic count_src_i = 0;
  logic phase_a_i = 0;
  logic phase_b_i = 0;
  logic ext_irq_pin_a_n_i = 1;
  logic ext_irq_pin_b_n_i = 1;
  logic [31:0] dat_o;
  logic ack_o;
  logic [15:0] count_o;
  logic count_down_o;
  int n_errors = 0;
  int total_checks = 0;
  updown_base_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .count_src_i(count_src_i),
    .phase_a_i(phase_a_i), .phase_b_i(phase_b_i), .ext_irq_pin_a_n_i(ext_irq_pin_a_n_i),
    .ext_irq_pin_b_n_i(ext_irq_pin_b_n_i), .count_o(count_o), .count_down_o(count_down_o));
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  // ==========================================================
  // Helpers
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Classic single cycle; waits for ack rather than assuming a latency
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, 4'hF};
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack_o !== 1'b1 && k < 20);
    r = dat_o;
    {cyc_i, stb_i} <= 2'h0;
    if (k >= 20) `CHK(ack_o, 1'b1)
  endtask
  // Control word: mode in [6:5], match enable and start bits in [2:0]
  function automatic logic [31:0] cw(input logic [1:0] m, input logic [2:0] f);
    return {25'h0, m, 2'h0, f};
  endfunction
  // Slow pulses leave room for the synchroniser and the count update
  task automatic tick(input int n);
    repeat (n)
    begin
      count_src_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      count_src_i <= 1'b0;
      repeat (5) @(posedge clk_i);
    end
  endtask
  // Clears count and direction through the external pin
  task automatic clr();
    ext_irq_pin_a_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    ext_irq_pin_a_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask
  // Triangle position after n pulses with peak p: {down, count}
  function automatic logic [16:0] tri_exp(input int n, input int p);
    int q;
    q = n % (2 * p);
    return {q >= p, q <= p ? 16'(q) : 16'(2 * p - q)};
  endfunction
  // Hang guard, far beyond the under one thousand cycles of the run
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    give_verdict();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    logic [31:0] r;
    int n;
    int p;
    n = $urandom(33625);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1, 4'h0, cw(base_timer_pkg::MODE_UP, 3'h1), r);
    n = $urandom_range(12, 2);
    tick(n);
    `CHK(count_o, 16'(n))
    wb(1, 4'h0, cw(base_timer_pkg::MODE_UP, 3'h0), r);
    tick(3);
    `CHK(count_o, 16'(n))
    wb(1, 4'h0, cw(base_timer_pkg::MODE_UP, 3'h2), r);
    tick(2);
    wb(0, 4'h8, 0, r);
    `CHK(r[15:0], 16'(n + 2))
    wb(0, 4'hC, 0, r);
    `CHK(r, 32'h0000_0001)
    wb(0, 4'h2, 0, r);
    wb(1, 4'h0, cw(base_timer_pkg::MODE_RESERVED, 3'h3), r);
    tick(2);
    `CHK(count_o, 16'(n + 2))
    // Each pin alone clears and holds the count
    for (int i = 0; i < 2; i++)
    begin
      wb(1, 4'h0, cw(base_timer_pkg::MODE_UP, 3'h1), r);
      tick(3);
      {ext_irq_pin_b_n_i, ext_irq_pin_a_n_i} <= 2'h3 ^ 2'(i + 1);
      tick(1);
      `CHK(count_o, 16'h0000)
      // Status while the pin is low: external reset and running, going up
      wb(0, 4'hC, 0, r);
      `CHK(r, 32'h0000_0005)
      {ext_irq_pin_b_n_i, ext_irq_pin_a_n_i} <= 2'h3;
      repeat (6) @(posedge clk_i);
    end
    // Triangle turning at compare zero plus two, boundary zero first
    for (int j = 0; j < 2; j++)
    begin
      p = j ? $urandom_range(6, 1) : 0;
      clr();
      wb(1, 4'h4, 32'(p), r);
      wb(0, 4'h4, 0, r);
      `CHK(r, 32'(p))
      wb(1, 4'h0, cw(base_timer_pkg::MODE_UPDOWN, 3'h5), r);
      for (int i = 1; i <= 4 * (p + 2) + 1; i++)
      begin
        tick(1);
        `CHK({count_down_o, count_o}, tri_exp(i, p + 2))
      end
    end
    // Two-phase: B set first, then A moves away from it for an up step
    clr();
    wb(1, 4'h0, cw(base_timer_pkg::MODE_TWO_PHASE, 3'h1), r);
    n = $urandom_range(9, 3);
    repeat (n)
    begin
      phase_b_i <= phase_a_i;
      repeat (4) @(posedge clk_i);
      phase_a_i <= ~phase_a_i;
      repeat (8) @(posedge clk_i);
    end
    `CHK(count_o, 16'(n))
    // Two steps with A landing on B's level count back down
    repeat (2)
    begin
      phase_b_i <= ~phase_a_i;
      repeat (4) @(posedge clk_i);
      phase_a_i <= ~phase_a_i;
      repeat (8) @(posedge clk_i);
    end
    `CHK({count_down_o, count_o}, {1'b1, 16'(n - 2)})
    give_verdict();
  end
endmodule

// ### tb/updown_base_timer_sva.sv
`timescale 1ns/100ps
// ==========================================================
// Port-level checks for the base timer
module updown_base_timer_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic count_src_i,
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  input wire logic ext_irq_pin_a_n_i,
  input wire logic ext_irq_pin_b_n_i,
  input wire logic [15:0] count_o,
  input wire logic count_down_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Bus handshake: one-cycle answer, one-cycle pulse
  chk_ack_on_time: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered after one cycle");
  chk_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");
  chk_idle_no_ack: assert property (!cyc_i |=> !ack_o)
    else $error("ack without a cycle");
  // ==========================================================
  // Counting; six quiet cycles cover the pin synchroniser delay
  chk_ext_clears: assert property ((!ext_irq_pin_a_n_i || !ext_irq_pin_b_n_i) [*6] |-> count_o == 16'h0000)
    else $error("count not cleared by low pin");
  chk_step_one: assert property ($changed(count_o) |-> count_o == $past(count_o) + 16'h0001
    || count_o == $past(count_o) - 16'h0001 || count_o == 16'h0000)
    else $error("count jumped by more than one");
  chk_hold_still: assert property (($stable(count_src_i) && $stable(phase_a_i) && $stable(phase_b_i)
    && ext_irq_pin_a_n_i && ext_irq_pin_b_n_i) [*6] |-> $stable(count_o))
    else $error("count moved without a pulse");
  chk_down_steps: assert property ($past(count_down_o) && $changed(count_o) && count_o != 16'h0000
    |-> count_o == $past(count_o) - 16'h0001)
    else $error("count rose while going down");
  chk_turn_moves: assert property ($rose(count_down_o) |-> $changed(count_o) && count_o != 16'h0000)
    else $error("direction turned without a step");
  chk_up_at_zero: assert property ($fell(count_down_o) |-> count_o == 16'h0000)
    else $error("direction turned up away from zero");
  chk_zero_up: assert property (count_o == 16'h0000 |-> !count_down_o)
    else $error("still going down at zero");
endmodule

bind updown_base_timer updown_base_timer_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .count_src_i(count_src_i), .phase_a_i(phase_a_i), .phase_b_i(phase_b_i),
  .ext_irq_pin_a_n_i(ext_irq_pin_a_n_i), .ext_irq_pin_b_n_i(ext_irq_pin_b_n_i), .count_o(count_o),
  .count_down_o(count_down_o));
